// >>> testbench/mds_chk.sv
// Concurrent checks on the ports of the multiply, divide and saturate unit.
module mds_chk #(
    parameter int unsigned ADDR_W = 4 // Register port address width.
) (
    input wire logic              core_clk,  // Core clock.
    input wire logic              arst_n,    // Asynchronous reset, active low.
    input wire logic              req_valid, // Operation issued.
    input wire mds_pkg::req_s     req,       // Operation and operands.
    input wire logic              refused,   // Refusal pulse.
    input wire mds_pkg::wb_s      wb,        // Write-back.
    input wire logic [ADDR_W-1:0] reg_addr,  // Register address.
    input wire logic [31:0]       reg_wdata, // Register write data.
    input wire logic              reg_wr,    // Register write strobe.
    input wire logic              reg_rd,    // Register read strobe.
    input wire logic [31:0]       reg_rdata, // Register read data.
    input wire logic              sat_flag   // Sticky saturation flag.
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    logic signed [31:0] half_exp; // Signed product of the selected halves.
    logic        [63:0] umac_exp; // Unsigned product plus destination pair.
    // Expected results worked out from the request of the same cycle.
    always_comb begin
        half_exp = $signed(req.x_top ? req.first_val[31:16] : req.first_val[15:0])
                 * $signed(req.y_top ? req.second_val[31:16] : req.second_val[15:0]);
        umac_exp = {req.acc_hi, req.acc_lo} + 64'(req.first_val) * 64'(req.second_val);
    end
    a_fail_no_write: assert property (req_valid && req.cond_fail |=> !wb.lo_en && !wb.hi_en && !refused)
        else $error("Condition-failed operation wrote or was refused.");
    a_fail_keeps_flag: assert property (req_valid && req.cond_fail && !reg_wr |=> $stable(sat_flag))
        else $error("Condition-failed operation changed the flag.");
    a_flag_clear_cause: assert property ($fell(sat_flag) |-> $past(reg_wr))
        else $error("Saturation flag cleared without a status write.");
    a_half_product: assert property (
        req_valid && !req.cond_fail && req.op == mds_pkg::HALFWORD_MULTIPLY
        |=> wb.lo_en && wb.lo_data == $past(half_exp))
        else $error("Halfword product wrong.");
    a_umac_sum: assert property (
        req_valid && !req.cond_fail && req.op == mds_pkg::UNSIGNED_LONG_MAC
        |=> {wb.hi_data, wb.lo_data} == $past(umac_exp))
        else $error("Unsigned accumulate sum wrong.");
    a_long_pair_idx: assert property (
        req_valid && !req.cond_fail && req.op inside {mds_pkg::UNSIGNED_LONG_MULTIPLY,
        mds_pkg::UNSIGNED_LONG_MAC, mds_pkg::SIGNED_LONG_MULTIPLY, mds_pkg::SIGNED_LONG_MAC}
        |=> wb.lo_en && wb.hi_en && wb.hi_idx == $past(req.hi_idx) && wb.lo_idx == $past(req.lo_idx))
        else $error("Long result pair not written together.");
    a_div_no_dest: assert property (
        req_valid && !req.cond_fail && !req.has_dest
        && req.op inside {mds_pkg::SIGNED_DIVIDE, mds_pkg::UNSIGNED_DIVIDE}
        |=> wb.lo_en && !wb.hi_en && wb.lo_idx == $past(req.first_idx))
        else $error("Quotient not written to the dividend register.");
    a_signed_width_refuse: assert property (
        req_valid && !req.cond_fail && req.op == mds_pkg::SIGNED_SATURATE
        && (req.sat_n == 6'h00 || req.sat_n > 6'h20) |=> refused && !wb.lo_en)
        else $error("Illegal signed width not refused.");
    a_status_readback: assert property (
        reg_rd && reg_addr == ADDR_W'(mds_pkg::STATUS_OFF)
        |=> reg_rdata == {31'h0, $past(sat_flag)})
        else $error("Status read does not show the flag.");
endmodule
bind mul_div_saturate_unit mds_chk #(.ADDR_W(ADDR_W)) chk_u (.core_clk(core_clk), .arst_n(arst_n),
    .req_valid(req_valid), .req(req), .refused(refused), .wb(wb), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sat_flag(sat_flag));

// >>> testbench/mds_regfile.sv
// Register-file model on the far side, taking the unit's write-backs.
module mds_regfile (
    input  wire logic         core_clk, // Core clock.
    input  wire logic         arst_n,   // Asynchronous reset, active low.
    input  wire mds_pkg::wb_s wb,       // Write-back from the unit.
    output logic [31:0]       rf [16]   // Register contents.
);
    timeunit 1ns;
    timeprecision 1ns;
    // Both channels land on the same edge, so a long result is never seen half written.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rf <= '{default: 32'h0};
        end else begin
            if (wb.lo_en) rf[wb.lo_idx] <= wb.lo_data;
            if (wb.hi_en) rf[wb.hi_idx] <= wb.hi_data;
        end
    end
endmodule

// >>> testbench/test_mul_div_saturate_unit.sv
// Self-checking testbench of the multiply, divide and saturate unit.
module test_mul_div_saturate_unit;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0, arst_n = 1'b0, req_valid = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0]     reg_addr = 4'h0;  // Register address.
    logic [31:0]    reg_wdata = 32'h0; // Register write data.
    mds_pkg::req_s  req = '0;          // Issued operation.
    logic           refused, sat_flag; // Unit status outputs.
    mds_pkg::wb_s   wb;                // Write-back.
    logic [31:0]    reg_rdata;         // Read data.
    logic [31:0]    rf [16];           // Far-side register file.
    int             err_total = 0, total_checks = 0;
    mul_div_saturate_unit #(.ADDR_W(4)) dut_u (.core_clk(core_clk), .arst_n(arst_n), .req_valid(req_valid),
        .req(req), .refused(refused), .wb(wb), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sat_flag(sat_flag));
    mds_regfile far_u (.core_clk(core_clk), .arst_n(arst_n), .wb(wb), .rf(rf));
    // Clock of 50 ns period.
    initial begin
        forever #25 core_clk = ~core_clk;
    end
    task automatic complete_run();
        if (err_total == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Builds a plain request with a given destination.
    function automatic mds_pkg::req_s mk(input mds_pkg::op_e op, input logic [31:0] a, input logic [31:0] b);
        mds_pkg::req_s r;
        r = '0;
        r.op = op;
        r.first_val = a;
        r.second_val = b;
        r.dest_idx = 4'h3;
        r.has_dest = 1'b1;
        return r;
    endfunction
    // Issues one operation and leaves the caller at the settled result cycle.
    task automatic issue(input mds_pkg::req_s r);
        @(posedge core_clk);
        req_valid <= 1'b1;
        req <= r;
        @(posedge core_clk);
        req_valid <= 1'b0;
        @(negedge core_clk);
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [3:0] a, input logic [31:0] e);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        chk("reg_rdata", {32'h0, e}, {32'h0, reg_rdata});
    endtask
    // Each of the four halfword selections, each followed by a word-by-half multiply on the same second-operand half.
    task automatic t_mul();
        mds_pkg::req_s r;
        logic signed [31:0] p;
        logic signed [47:0] w;
        for (int i = 0; i < 4; i++) begin
            r = mk(mds_pkg::HALFWORD_MULTIPLY, 32'h8000_0003, 32'h7FFF_FFFE);
            {r.y_top, r.x_top} = 2'(i);
            p = $signed(i[0] ? 16'h8000 : 16'h0003) * $signed(i[1] ? 16'h7FFF : 16'hFFFE);
            issue(r);
            chk("half_mul", {27'h0, 1'b1, 4'h3, p}, {27'h0, wb.lo_en, wb.lo_idx, wb.lo_data});
            r.op = mds_pkg::WORD_BY_HALF_MULTIPLY;
            w = $signed(32'h8000_0003) * $signed(i[1] ? 16'h7FFF : 16'hFFFE);
            issue(r);
            chk("word_half_mul", {32'h0, w[47:16]}, {32'h0, wb.lo_data});
        end
    endtask
    // The four long variants on one operand set, checked on the wire and in the file.
    task automatic t_long();
        mds_pkg::op_e ops [4] = '{mds_pkg::UNSIGNED_LONG_MULTIPLY, mds_pkg::UNSIGNED_LONG_MAC,
                                   mds_pkg::SIGNED_LONG_MULTIPLY, mds_pkg::SIGNED_LONG_MAC};
        logic [63:0] acc = 64'h0000_0001_FFFF_FFFF;
        logic [63:0] e [4];
        mds_pkg::req_s r;
        e[0] = 64'(32'hFFFF_FFFE) * 64'(32'h0000_0003);
        e[1] = e[0] + acc;
        e[2] = 64'hFFFF_FFFF_FFFF_FFFA;
        e[3] = e[2] + acc;
        for (int i = 0; i < 4; i++) begin
            r = mk(ops[i], 32'hFFFF_FFFE, 32'h0000_0003);
            {r.acc_hi, r.acc_lo} = acc;
            r.hi_idx = 4'h5;
            r.lo_idx = 4'h6;
            issue(r);
            chk("long_wire", e[i], {wb.hi_data, wb.lo_data});
            @(negedge core_clk);
            chk("long_file", e[i], {rf[5], rf[6]});
        end
    endtask
    // Inexact quotients of both signs, with and without a given destination.
    task automatic t_div();
        logic [31:0] dv [4] = '{32'hFFFF_FFF9, 32'h0000_0007, 32'hFFFF_FFFF, 32'h0000_0007};
        logic [31:0] ds [4] = '{32'h0000_0002, 32'hFFFF_FFFE, 32'h0000_0002, 32'h0000_0002};
        logic [31:0] q [4] = '{32'hFFFF_FFFD, 32'hFFFF_FFFD, 32'h7FFF_FFFF, 32'h0000_0003};
        mds_pkg::req_s r;
        for (int i = 0; i < 4; i++) begin
            r = mk(i < 2 ? mds_pkg::SIGNED_DIVIDE : mds_pkg::UNSIGNED_DIVIDE, dv[i], ds[i]);
            r.first_idx = 4'h7;
            r.has_dest = i[0];
            issue(r);
            chk("divide", {26'h0, 2'b01, i[0] ? 4'h3 : 4'h7, q[i]},
                {26'h0, wb.hi_en, wb.lo_en, wb.lo_idx, wb.lo_data});
        end
    endtask
    // One saturate request, judged on refusal, flag, enable and data.
    task automatic sat(input mds_pkg::op_e op, input logic [5:0] n, input mds_pkg::shift_e k,
                       input logic [4:0] s, input logic [31:0] v, input logic cf, input logic [34:0] e);
        mds_pkg::req_s r;
        r = mk(op, 32'h0, v);
        r.sat_n = n;
        r.shift_kind = k;
        r.shift_amt = s;
        r.cond_fail = cf;
        issue(r);
        chk("saturate", {29'h0, e}, {29'h0, refused, sat_flag, wb.lo_en, wb.lo_en ? wb.lo_data : 32'h0});
    endtask
    // Saturation cases in order, then the status register seen and cleared over the bus.
    task automatic t_sat();
        reg_write(mds_pkg::STATUS_OFF, 32'h0);
        sat(mds_pkg::SIGNED_SATURATE, 6'h08, mds_pkg::ARITH_RIGHT_SHIFT, 5'h01, 32'hFFFF_FFF8, 1'b0,
            {3'b001, 32'hFFFF_FFFC});
        sat(mds_pkg::SIGNED_SATURATE, 6'h08, mds_pkg::LOGICAL_LEFT_SHIFT, 5'h00, 32'h0000_012C, 1'b1,
            {3'b000, 32'h0});
        sat(mds_pkg::SIGNED_SATURATE, 6'h08, mds_pkg::LOGICAL_LEFT_SHIFT, 5'h04, 32'h0000_0010, 1'b0,
            {3'b011, 32'h0000_007F});
        sat(mds_pkg::SIGNED_SATURATE, 6'h08, mds_pkg::LOGICAL_LEFT_SHIFT, 5'h00, 32'hFFFF_FED4, 1'b0,
            {3'b011, 32'hFFFF_FF80});
        sat(mds_pkg::UNSIGNED_SATURATE, 6'h08, mds_pkg::LOGICAL_LEFT_SHIFT, 5'h00, 32'hFFFF_FFFB, 1'b0,
            {3'b011, 32'h0});
        sat(mds_pkg::UNSIGNED_SATURATE, 6'h08, mds_pkg::LOGICAL_LEFT_SHIFT, 5'h00, 32'h0000_012C, 1'b0,
            {3'b011, 32'h0000_00FF});
        sat(mds_pkg::SIGNED_SATURATE, 6'h00, mds_pkg::LOGICAL_LEFT_SHIFT, 5'h00, 32'h0000_0001, 1'b0,
            {3'b110, 32'h0});
        sat(mds_pkg::UNSIGNED_SATURATE, 6'h20, mds_pkg::LOGICAL_LEFT_SHIFT, 5'h00, 32'h0000_0001, 1'b0,
            {3'b110, 32'h0});
        sat(mds_pkg::SIGNED_SATURATE, 6'h08, mds_pkg::ARITH_RIGHT_SHIFT, 5'h00, 32'h0000_0001, 1'b0,
            {3'b110, 32'h0});
        sat(mds_pkg::SIGNED_SATURATE, 6'h20, mds_pkg::LOGICAL_LEFT_SHIFT, 5'h00, 32'h8000_0000, 1'b0,
            {3'b011, 32'h8000_0000});
        reg_read(mds_pkg::STATUS_OFF, 32'h1);
        reg_write(mds_pkg::STATUS_OFF, 32'h0);
        reg_read(mds_pkg::STATUS_OFF, 32'h0);
        reg_read(mds_pkg::LAST_LO_OFF, 32'h8000_0000);
        reg_read(4'h2, 32'h0);
        // A clamp in the same cycle as a clearing write leaves the flag set.
        fork
            reg_write(mds_pkg::STATUS_OFF, 32'h0);
            sat(mds_pkg::SIGNED_SATURATE, 6'h08, mds_pkg::LOGICAL_LEFT_SHIFT, 5'h00, 32'h0000_012C, 1'b0,
                {3'b011, 32'h0000_007F});
        join
        reg_read(mds_pkg::STATUS_OFF, 32'h1);
        reg_read(mds_pkg::OP_COUNT_OFF, 32'h0000_0017);
        reg_read(mds_pkg::LAST_HI_OFF, 32'h0000_0001);
    endtask
    // Watchdog well beyond the hundred or fewer cycles the tests take.
    initial begin
        repeat (5000) @(posedge core_clk);
        err_total++;
        complete_run();
    end
    // Reset for two cycles, then every scenario in turn.
    initial begin
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        t_mul();
        t_long();
        t_div();
        t_sat();
        complete_run();
    end
endmodule

// >>> verilog/mds_pkg.sv
// Package with types and constants for the multiply, divide and saturate unit.
package mds_pkg;

    // Width of a register-file index.
    localparam int unsigned IDX_W = 4;
    typedef logic [IDX_W-1:0] reg_idx_t;

    // Register offsets on the plain register port.
    localparam logic [3:0] STATUS_OFF   = 4'h0; // Status, sticky saturation flag.
    localparam logic [3:0] LAST_LO_OFF  = 4'h4; // Last low or single result.
    localparam logic [3:0] LAST_HI_OFF  = 4'h8; // Last high result.
    localparam logic [3:0] OP_COUNT_OFF = 4'hC; // Count of retired operations.

    // Field position and reset values.
    localparam int unsigned SAT_FLAG_BIT = 0;
    localparam logic        SAT_FLAG_RST = 1'b0;
    localparam logic [31:0] WORD_RST     = 32'h0000_0000;

    // Legal ranges of the saturation width and the pre-shift amount.
    localparam logic [5:0] SIGNED_N_MIN    = 6'h01;
    localparam logic [5:0] SIGNED_N_MAX    = 6'h20;
    localparam logic [5:0] UNSIGNED_N_MAX  = 6'h1F;
    localparam logic [4:0] RIGHT_SHIFT_MIN = 5'h01;

    // Divide special values.
    localparam logic [31:0] INT_MIN_W = 32'h8000_0000;
    localparam logic [31:0] ALL_ONES  = 32'hFFFF_FFFF;

    // Operation selector.
    typedef enum logic [3:0] {
        HALFWORD_MULTIPLY,
        WORD_BY_HALF_MULTIPLY,
        UNSIGNED_LONG_MULTIPLY,
        UNSIGNED_LONG_MAC,
        SIGNED_LONG_MULTIPLY,
        SIGNED_LONG_MAC,
        SIGNED_DIVIDE,
        UNSIGNED_DIVIDE,
        SIGNED_SATURATE,
        UNSIGNED_SATURATE
    } op_e;

    // Pre-shift kind for saturation.
    typedef enum logic {
        LOGICAL_LEFT_SHIFT,
        ARITH_RIGHT_SHIFT
    } shift_e;

    // One issued operation.
    typedef struct packed {
        op_e         op;         // Operation.
        logic        x_top;      // First operand uses bits 31..16.
        logic        y_top;      // Second operand uses bits 31..16.
        logic [31:0] first_val;  // First operand value.
        logic [31:0] second_val; // Second operand value.
        logic [31:0] acc_hi;     // High destination value.
        logic [31:0] acc_lo;     // Low destination value.
        reg_idx_t    first_idx;  // First operand index.
        reg_idx_t    dest_idx;   // Single destination index.
        logic        has_dest;   // Destination index is given.
        reg_idx_t    hi_idx;     // High destination index.
        reg_idx_t    lo_idx;     // Low destination index.
        logic [5:0]  sat_n;      // Saturation width.
        shift_e      shift_kind; // Pre-shift kind.
        logic [4:0]  shift_amt;  // Pre-shift amount.
        logic        cond_fail;  // Condition failed, write nothing.
    } req_s;

    // Register-file write-back, two channels.
    typedef struct packed {
        logic        lo_en;   // Low or single write enable.
        reg_idx_t    lo_idx;  // Low or single write index.
        logic [31:0] lo_data; // Low or single write data.
        logic        hi_en;   // High write enable.
        reg_idx_t    hi_idx;  // High write index.
        logic [31:0] hi_data; // High write data.
    } wb_s;

endpackage

// >>> verilog/mul_div_saturate_unit.sv
// Single-cycle multiply, divide and saturate execution unit with status port.
//
// Implementation choices: the address-and-strobe port and the register offsets.
module mul_div_saturate_unit #(
    parameter int unsigned ADDR_W = 4 // Register port address width.
) (
    input  wire logic              core_clk,  // Core clock.
    input  wire logic              arst_n,    // Asynchronous reset, active low.
    input  wire logic              req_valid, // Operation issued this cycle.
    input  wire mds_pkg::req_s     req,       // Operation and operands.
    output logic                   refused,   // Pulse: request had bad field.
    output mds_pkg::wb_s           wb,        // Registered write-back.
    input  wire logic [ADDR_W-1:0] reg_addr,  // Register byte address.
    input  wire logic [31:0]       reg_wdata, // Register write data.
    input  wire logic              reg_wr,    // Register write strobe.
    input  wire logic              reg_rd,    // Register read strobe.
    output logic [31:0]            reg_rdata, // Read data, cycle after strobe.
    output logic                   sat_flag   // Sticky saturation flag level.
);

    // Offsets up to 0xC need four address bits.
    if (ADDR_W < 4) begin : g_chk
        $error("ADDR_W must be at least 4");
    end

    // Whole state of the unit.
    typedef struct packed {
        mds_pkg::wb_s wb;       // Write-back outputs.
        logic         refused;  // Refusal pulse.
        logic         sat_flag; // Sticky saturation flag.
        logic [31:0]  rdata;    // Read data.
        logic [31:0]  last_lo;  // Last low result.
        logic [31:0]  last_hi;  // Last high result.
        logic [31:0]  op_count; // Retired operations.
    } state_s;

    state_s st_reg;  // Registered state.
    state_s st_next; // Next state.

    // Datapath intermediates.
    logic signed [15:0] half_a;     // Selected first halfword.
    logic signed [15:0] half_b;     // Selected second halfword.
    logic signed [31:0] half_prod;  // Halfword product.
    logic signed [47:0] wh_prod;    // Word by halfword product.
    logic        [63:0] u_prod;     // Unsigned long product.
    logic signed [63:0] s_prod;     // Signed long product.
    logic        [63:0] acc_pair;   // Destination pair value.
    logic        [31:0] s_quot;     // Signed quotient.
    logic        [31:0] u_quot;     // Unsigned quotient.
    logic        [31:0] shifted;    // Pre-shifted saturate source.
    logic signed [63:0] sat_x;      // Sign-extended shifted value.
    logic signed [63:0] s_max;      // Signed upper bound.
    logic signed [63:0] s_min;      // Signed lower bound.
    logic signed [63:0] u_max;      // Unsigned upper bound.
    logic        [31:0] s_sat;      // Signed saturate result.
    logic        [31:0] u_sat;      // Unsigned saturate result.
    logic               s_clamped;  // Signed clamp happened.
    logic               u_clamped;  // Unsigned clamp happened.
    logic               bad_field;  // Width or shift out of range.

    // Operand selection and products.
    always_comb begin
        half_a    = req.x_top ? req.first_val[31:16] : req.first_val[15:0];
        half_b    = req.y_top ? req.second_val[31:16] : req.second_val[15:0];
        half_prod = half_a * half_b;
        wh_prod   = $signed(req.first_val) * half_b;
        u_prod    = {32'h0000_0000, req.first_val} * {32'h0000_0000, req.second_val};
        s_prod    = $signed({{32{req.first_val[31]}}, req.first_val})
                  * $signed({{32{req.second_val[31]}}, req.second_val});
        acc_pair  = {req.acc_hi, req.acc_lo};
    end

    // Division; both quotients truncate toward zero.
    always_comb begin
        if (req.second_val == 32'h0000_0000) begin
            // Divide by zero returns zero.
            s_quot = 32'h0000_0000;
            u_quot = 32'h0000_0000;
        end else begin
            u_quot = req.first_val / req.second_val;
            if (req.first_val == mds_pkg::INT_MIN_W && req.second_val == mds_pkg::ALL_ONES) begin
                // The one overflowing case wraps to the most negative value.
                s_quot = mds_pkg::INT_MIN_W;
            end else begin
                s_quot = 32'($signed(req.first_val) / $signed(req.second_val));
            end
        end
    end

    // Pre-shift then clamp to the requested range.
    always_comb begin
        if (req.shift_kind == mds_pkg::ARITH_RIGHT_SHIFT) begin
            shifted = 32'($signed(req.second_val) >>> req.shift_amt);
        end else begin
            shifted = req.second_val << req.shift_amt;
        end
        sat_x = $signed({{32{shifted[31]}}, shifted});
        s_max = (64'sh1 <<< 6'(req.sat_n - 6'h01)) - 64'sh1;
        s_min = -s_max - 64'sh1;
        u_max = (64'sh1 <<< req.sat_n) - 64'sh1;
        // Signed clamp.
        if (sat_x < s_min) begin
            s_sat     = s_min[31:0];
            s_clamped = 1'b1;
        end else if (sat_x > s_max) begin
            s_sat     = s_max[31:0];
            s_clamped = 1'b1;
        end else begin
            s_sat     = shifted;
            s_clamped = 1'b0;
        end
        // Unsigned clamp.
        if (sat_x < 64'sh0) begin
            u_sat     = 32'h0000_0000;
            u_clamped = 1'b1;
        end else if (sat_x > u_max) begin
            u_sat     = u_max[31:0];
            u_clamped = 1'b1;
        end else begin
            u_sat     = shifted;
            u_clamped = 1'b0;
        end
    end

    // Range check of width and shift fields.
    always_comb begin
        bad_field = 1'b0;
        if (req.op == mds_pkg::SIGNED_SATURATE || req.op == mds_pkg::UNSIGNED_SATURATE) begin
            if (req.shift_kind == mds_pkg::ARITH_RIGHT_SHIFT && req.shift_amt < mds_pkg::RIGHT_SHIFT_MIN) begin
                bad_field = 1'b1;
            end
            if (req.op == mds_pkg::SIGNED_SATURATE) begin
                bad_field = bad_field | (req.sat_n < mds_pkg::SIGNED_N_MIN)
                          | (req.sat_n > mds_pkg::SIGNED_N_MAX);
            end else begin
                bad_field = bad_field | (req.sat_n > mds_pkg::UNSIGNED_N_MAX);
            end
        end
    end

    // Next-state logic: write-back, flag and register port.
    always_comb begin
        logic go;     // Operation retires this cycle.
        logic clamp;  // Saturation happened.
        go      = req_valid & ~req.cond_fail & ~bad_field;
        clamp   = 1'b0;
        st_next = st_reg;
        st_next.wb.lo_en = 1'b0;
        st_next.wb.hi_en = 1'b0;
        st_next.refused  = req_valid & ~req.cond_fail & bad_field;
        st_next.rdata    = 32'h0000_0000;
        if (go) begin
            // Single results go out on the low channel.
            st_next.wb.lo_en  = 1'b1;
            st_next.wb.lo_idx = req.dest_idx;
            st_next.wb.hi_idx = req.hi_idx;
            case (req.op)
                mds_pkg::HALFWORD_MULTIPLY: begin
                    st_next.wb.lo_data = half_prod;
                end
                mds_pkg::WORD_BY_HALF_MULTIPLY: begin
                    st_next.wb.lo_data = wh_prod[47:16];
                end
                mds_pkg::UNSIGNED_LONG_MULTIPLY: begin
                    {st_next.wb.hi_data, st_next.wb.lo_data} = u_prod;
                end
                mds_pkg::UNSIGNED_LONG_MAC: begin
                    {st_next.wb.hi_data, st_next.wb.lo_data} = u_prod + acc_pair;
                end
                mds_pkg::SIGNED_LONG_MULTIPLY: begin
                    {st_next.wb.hi_data, st_next.wb.lo_data} = s_prod;
                end
                mds_pkg::SIGNED_LONG_MAC: begin
                    {st_next.wb.hi_data, st_next.wb.lo_data} = s_prod + acc_pair;
                end
                mds_pkg::SIGNED_DIVIDE, mds_pkg::UNSIGNED_DIVIDE: begin
                    // Missing destination falls back to the dividend register.
                    st_next.wb.lo_idx  = req.has_dest ? req.dest_idx : req.first_idx;
                    st_next.wb.lo_data = (req.op == mds_pkg::SIGNED_DIVIDE) ? s_quot : u_quot;
                end
                mds_pkg::SIGNED_SATURATE: begin
                    st_next.wb.lo_data = s_sat;
                    clamp              = s_clamped;
                end
                mds_pkg::UNSIGNED_SATURATE: begin
                    st_next.wb.lo_data = u_sat;
                    clamp              = u_clamped;
                end
                default: begin
                    st_next.wb.lo_en = 1'b0;
                end
            endcase
            // Long forms write the pair; the issuer keeps the indices apart.
            if (req.op == mds_pkg::UNSIGNED_LONG_MULTIPLY || req.op == mds_pkg::UNSIGNED_LONG_MAC
                || req.op == mds_pkg::SIGNED_LONG_MULTIPLY || req.op == mds_pkg::SIGNED_LONG_MAC) begin
                st_next.wb.lo_idx = req.lo_idx;
                st_next.wb.hi_en  = 1'b1;
            end
            st_next.last_lo  = st_next.wb.lo_data;
            st_next.last_hi  = st_next.wb.hi_data;
            // Only operations that really wrote a result are counted.
            st_next.op_count = st_reg.op_count + 32'(st_next.wb.lo_en);
        end
        // Status write loads the flag; a clamp in the same cycle wins.
        if (reg_wr && reg_addr == ADDR_W'(mds_pkg::STATUS_OFF)) begin
            st_next.sat_flag = reg_wdata[mds_pkg::SAT_FLAG_BIT];
        end
        if (clamp) begin
            st_next.sat_flag = 1'b1;
        end
        // Reads answer in the next cycle; unmapped reads return zero.
        if (reg_rd) begin
            case (reg_addr)
                ADDR_W'(mds_pkg::STATUS_OFF): begin
                    st_next.rdata[mds_pkg::SAT_FLAG_BIT] = st_reg.sat_flag;
                end
                ADDR_W'(mds_pkg::LAST_LO_OFF): begin
                    st_next.rdata = st_reg.last_lo;
                end
                ADDR_W'(mds_pkg::LAST_HI_OFF): begin
                    st_next.rdata = st_reg.last_hi;
                end
                ADDR_W'(mds_pkg::OP_COUNT_OFF): begin
                    st_next.rdata = st_reg.op_count;
                end
                default: begin
                    st_next.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // State register; no condition flag is held or touched here.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg            <= '0;
            st_reg.sat_flag   <= mds_pkg::SAT_FLAG_RST;
            st_reg.last_lo    <= mds_pkg::WORD_RST;
            st_reg.last_hi    <= mds_pkg::WORD_RST;
            st_reg.op_count   <= mds_pkg::WORD_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state register.
    assign wb        = st_reg.wb;
    assign refused   = st_reg.refused;
    assign reg_rdata = st_reg.rdata;
    assign sat_flag  = st_reg.sat_flag;

endmodule
